/* src/jump_unit_pkg.sv */
// Constants and types shared by the status conditional jump unit
package jump_unit_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned PC_WIDTH = 16;
    localparam int unsigned DISP_WIDTH = 16;
    localparam int unsigned LEN_WIDTH = 2;
    localparam int unsigned CC_WIDTH = 2;

    // ------------------------------------------------------------
    // Displacement range in code words
    // ------------------------------------------------------------
    localparam logic signed [DISP_WIDTH-1:0] DISP_MIN = 16'sh8000;
    localparam logic signed [DISP_WIDTH-1:0] DISP_MAX = 16'sh7fff;

    // ------------------------------------------------------------
    // Statement lengths in code words
    // ------------------------------------------------------------
    localparam logic [LEN_WIDTH-1:0] LEN_MIN = 2'h1;
    localparam logic [LEN_WIDTH-1:0] LEN_MAX = 2'h3;

    // ------------------------------------------------------------
    // Condition-code pair, high bit then low bit
    // ------------------------------------------------------------
    localparam logic [CC_WIDTH-1:0] CC_ZERO = 2'h0;
    localparam logic [CC_WIDTH-1:0] CC_NEGATIVE = 2'h1;
    localparam logic [CC_WIDTH-1:0] CC_POSITIVE = 2'h2;
    localparam logic [CC_WIDTH-1:0] CC_UNORDERED = 2'h3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [PC_WIDTH-1:0] PC_RESET = 16'h0000;
    localparam logic [CC_WIDTH-1:0] CC_RESET = 2'h0;
    localparam logic FLAG_RESET = 1'b0;

    // ------------------------------------------------------------
    // Jump kinds handled here
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        jump_if_sticky_overflow,
        jump_if_overflow,
        jump_if_zero,
        jump_if_nonzero,
        jump_if_positive,
        jump_if_negative,
        jump_if_nonnegative
    } jump_kind_t;

endpackage : jump_unit_pkg

/* src/status_conditional_jump_unit.sv */
// Branch-condition unit: status word upkeep and conditional program-counter redirect
`timescale 1ns/10ps
`default_nettype none

module status_conditional_jump_unit (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic exec_valid_i,
    input wire jump_unit_pkg::jump_kind_t exec_kind_i,
    input wire logic [jump_unit_pkg::PC_WIDTH-1:0] exec_pc_i,
    input wire logic [jump_unit_pkg::LEN_WIDTH-1:0] exec_length_i,
    input wire logic [jump_unit_pkg::DISP_WIDTH-1:0] exec_disp_i,
    input wire logic arith_valid_i,
    input wire logic [jump_unit_pkg::CC_WIDTH-1:0] arith_cc_i,
    input wire logic arith_overflow_i,
    output logic [jump_unit_pkg::PC_WIDTH-1:0] next_pc_o,
    output logic done_o,
    output logic redirect_o,
    output logic flush_o,
    output logic condition_code_high_o,
    output logic condition_code_low_o,
    output logic overflow_flag_o,
    output logic sticky_overflow_flag_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [jump_unit_pkg::PC_WIDTH-1:0] pc;
        logic done;
        logic redirect;
        logic flush;
        logic [jump_unit_pkg::CC_WIDTH-1:0] cc;
        logic overflow_flag;
        logic sticky_overflow_flag;
    } unit_state_t;

    unit_state_t state;
    unit_state_t next_state;

    logic [jump_unit_pkg::CC_WIDTH-1:0] eff_cc;
    logic eff_overflow;
    logic eff_sticky;
    logic cond;
    logic [jump_unit_pkg::PC_WIDTH-1:0] target_pc;
    logic [jump_unit_pkg::PC_WIDTH-1:0] fall_pc;

    // ------------------------------------------------------------
    // Condition decode
    // ------------------------------------------------------------
    function automatic logic jump_condition(
        input jump_unit_pkg::jump_kind_t kind,
        input logic [jump_unit_pkg::CC_WIDTH-1:0] cc,
        input logic overflow,
        input logic sticky
    );
        logic hit;
        hit = 1'b0;
        unique case (kind)
            jump_unit_pkg::jump_if_sticky_overflow: hit = sticky;
            jump_unit_pkg::jump_if_overflow: hit = overflow;
            jump_unit_pkg::jump_if_zero: hit = (cc == jump_unit_pkg::CC_ZERO);
            jump_unit_pkg::jump_if_nonzero: begin
                hit = (cc == jump_unit_pkg::CC_NEGATIVE) || (cc == jump_unit_pkg::CC_POSITIVE);
            end
            jump_unit_pkg::jump_if_positive: hit = (cc == jump_unit_pkg::CC_POSITIVE);
            jump_unit_pkg::jump_if_negative: hit = (cc == jump_unit_pkg::CC_NEGATIVE);
            jump_unit_pkg::jump_if_nonnegative: begin
                hit = (cc == jump_unit_pkg::CC_ZERO) || (cc == jump_unit_pkg::CC_POSITIVE);
            end
            default: hit = 1'b0;
        endcase
        // Pair 11 matches none of the sign tests above by construction
        return hit;
    endfunction : jump_condition

    function automatic logic is_cc_kind(input jump_unit_pkg::jump_kind_t kind);
        return (kind != jump_unit_pkg::jump_if_sticky_overflow) && (kind != jump_unit_pkg::jump_if_overflow);
    endfunction : is_cc_kind

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        // Arithmetic finishing this cycle counts as completed before the jump
        eff_cc = arith_valid_i ? arith_cc_i : state.cc;
        eff_overflow = arith_valid_i ? arith_overflow_i : state.overflow_flag;
        eff_sticky = state.sticky_overflow_flag | (arith_valid_i & arith_overflow_i);
        cond = jump_condition(exec_kind_i, eff_cc, eff_overflow, eff_sticky);
        // Wraps inside the 64K-word block; cross-block targets are not supported
        target_pc = exec_pc_i + exec_disp_i;
        fall_pc = exec_pc_i + {{(jump_unit_pkg::PC_WIDTH-jump_unit_pkg::LEN_WIDTH){1'b0}}, exec_length_i};

        next_state = state;
        next_state.done = 1'b0;
        next_state.redirect = 1'b0;
        next_state.flush = 1'b0;

        if (arith_valid_i) begin
            next_state.cc = arith_cc_i;
            next_state.overflow_flag = arith_overflow_i;
            next_state.sticky_overflow_flag = eff_sticky;
        end

        if (exec_valid_i) begin
            next_state.done = 1'b1;
            if (cond) begin
                next_state.pc = target_pc;
                next_state.redirect = 1'b1;
                next_state.flush = 1'b1;
            end else begin
                next_state.pc = fall_pc;
            end
            if (exec_kind_i == jump_unit_pkg::jump_if_sticky_overflow) begin
                next_state.sticky_overflow_flag = 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state.pc <= jump_unit_pkg::PC_RESET;
            state.done <= 1'b0;
            state.redirect <= 1'b0;
            state.flush <= 1'b0;
            state.cc <= jump_unit_pkg::CC_RESET;
            state.overflow_flag <= jump_unit_pkg::FLAG_RESET;
            state.sticky_overflow_flag <= jump_unit_pkg::FLAG_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign next_pc_o = state.pc;
    assign done_o = state.done;
    assign redirect_o = state.redirect;
    assign flush_o = state.flush;
    assign condition_code_high_o = state.cc[1];
    assign condition_code_low_o = state.cc[0];
    assign overflow_flag_o = state.overflow_flag;
    assign sticky_overflow_flag_o = state.sticky_overflow_flag;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    sticky_clear_a: assert property (
        exec_valid_i && exec_kind_i == jump_unit_pkg::jump_if_sticky_overflow |=> !sticky_overflow_flag_o
    ) else $error("sticky flag not cleared by sticky jump");

    sticky_taken_a: assert property (
        exec_valid_i && exec_kind_i == jump_unit_pkg::jump_if_sticky_overflow && eff_sticky
        |=> redirect_o && next_pc_o == $past(target_pc)
    ) else $error("sticky jump not taken to target");

    zero_jump_a: assert property (
        exec_valid_i && exec_kind_i == jump_unit_pkg::jump_if_zero |=> redirect_o == ($past(eff_cc) == 2'h0)
    ) else $error("zero jump decision wrong");

    nonzero_jump_a: assert property (
        exec_valid_i && exec_kind_i == jump_unit_pkg::jump_if_nonzero
        |=> redirect_o == ($past(eff_cc) == 2'h1 || $past(eff_cc) == 2'h2)
    ) else $error("nonzero jump decision wrong");

    plus_jump_a: assert property (
        exec_valid_i && exec_kind_i == jump_unit_pkg::jump_if_positive |=> redirect_o == ($past(eff_cc) == 2'h2)
    ) else $error("plus jump decision wrong");

    minus_jump_a: assert property (
        exec_valid_i && exec_kind_i == jump_unit_pkg::jump_if_negative |=> redirect_o == ($past(eff_cc) == 2'h1)
    ) else $error("minus jump decision wrong");

    nonneg_jump_a: assert property (
        exec_valid_i && exec_kind_i == jump_unit_pkg::jump_if_nonnegative
        |=> redirect_o == ($past(eff_cc) == 2'h0 || $past(eff_cc) == 2'h2)
    ) else $error("plus-or-zero jump decision wrong");

    status_hold_a: assert property (
        exec_valid_i && is_cc_kind(exec_kind_i) && !arith_valid_i
        |=> $stable({condition_code_high_o, condition_code_low_o, overflow_flag_o, sticky_overflow_flag_o})
    ) else $error("condition-code jump changed status");

    fall_through_a: assert property (
        exec_valid_i && !cond |=> done_o && !redirect_o && next_pc_o == $past(fall_pc)
    ) else $error("untaken jump did not fall through");

    unordered_a: assert property (
        exec_valid_i && is_cc_kind(exec_kind_i) && exec_kind_i != jump_unit_pkg::jump_if_overflow
        && eff_cc == jump_unit_pkg::CC_UNORDERED |=> done_o && !redirect_o
    ) else $error("pair 11 treated as sign");

    sticky_keep_a: assert property (
        sticky_overflow_flag_o && !(exec_valid_i && exec_kind_i == jump_unit_pkg::jump_if_sticky_overflow)
        |=> sticky_overflow_flag_o
    ) else $error("sticky flag lost");

    flush_pair_a: assert property (
        redirect_o == flush_o
    ) else $error("taken jump without flush");

    // ------------------------------------------------------------
    // Outcome checks worked out from the ports
    // ------------------------------------------------------------
    // Kept apart from the internal sums so a slip in the adders shows up
    target_sum_a: assert property (
        exec_valid_i && cond
        |=> redirect_o && next_pc_o == $past(exec_pc_i) + $past(exec_disp_i)
    ) else $error("taken jump landed off target");

    fall_words_a: assert property (
        exec_valid_i && !cond
        |=> next_pc_o - $past(exec_pc_i) == {14'h0000, $past(exec_length_i)}
    ) else $error("fall-through skipped wrong word count");

    done_pulse_a: assert property (
        exec_valid_i
        |=> done_o
    ) else $error("jump not resolved next cycle");

    pulse_end_a: assert property (
        !exec_valid_i
        |=> !done_o && !redirect_o && !flush_o
    ) else $error("jump pulse outlived its cycle");

    pc_hold_a: assert property (
        !exec_valid_i
        |=> $stable(next_pc_o)
    ) else $error("resume address moved without a jump");

    redirect_done_a: assert property (
        redirect_o
        |-> done_o
    ) else $error("flush without a resolved jump");

    // ------------------------------------------------------------
    // Status word checks
    // ------------------------------------------------------------
    cc_load_a: assert property (
        arith_valid_i
        |=> {condition_code_high_o, condition_code_low_o} == $past(arith_cc_i)
    ) else $error("condition-code pair not loaded");

    ov_track_a: assert property (
        arith_valid_i
        |=> overflow_flag_o == $past(arith_overflow_i)
    ) else $error("plain overflow not from latest arithmetic");

    ov_jump_a: assert property (
        exec_valid_i && exec_kind_i == jump_unit_pkg::jump_if_overflow
        |=> redirect_o == $past(eff_overflow)
    ) else $error("overflow jump decision wrong");

    sticky_set_a: assert property (
        arith_valid_i && arith_overflow_i && !(exec_valid_i && exec_kind_i == jump_unit_pkg::jump_if_sticky_overflow)
        |=> sticky_overflow_flag_o
    ) else $error("overflow did not set sticky flag");

    sticky_source_a: assert property (
        !sticky_overflow_flag_o && !(arith_valid_i && arith_overflow_i)
        |=> !sticky_overflow_flag_o
    ) else $error("sticky flag set without overflow");

    // Nothing but arithmetic may move the pair or the plain overflow
    status_idle_a: assert property (
        !arith_valid_i
        |=> $stable({condition_code_high_o, condition_code_low_o, overflow_flag_o})
    ) else $error("status moved without arithmetic");

    // Same-cycle arithmetic must steer the jump, never the stale status
    bypass_zero_a: assert property (
        exec_valid_i && arith_valid_i && exec_kind_i == jump_unit_pkg::jump_if_zero
        |=> redirect_o == ($past(arith_cc_i) == jump_unit_pkg::CC_ZERO)
    ) else $error("zero jump ignored same-cycle result");

    bypass_sticky_a: assert property (
        exec_valid_i && arith_valid_i && arith_overflow_i && exec_kind_i == jump_unit_pkg::jump_if_sticky_overflow
        |=> redirect_o && !sticky_overflow_flag_o
    ) else $error("sticky jump missed same-cycle overflow");

endmodule : status_conditional_jump_unit

`default_nettype wire

/* tb/code_memory_model.sv */
// Code memory side: tracks where the next statement is fetched from
`timescale 1ns/10ps
`default_nettype none
module code_memory_model (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic done_i,
    input wire logic flush_i,
    input wire logic [15:0] next_pc_i,
    output logic [15:0] fetch_pc_o
);
    // Prefetch runs ahead one word; a resolved jump restarts it
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            fetch_pc_o <= 16'h0000;
        end else if (flush_i || done_i) begin
            fetch_pc_o <= next_pc_i;
        end else begin
            fetch_pc_o <= fetch_pc_o + 16'h0001;
        end
    end
endmodule : code_memory_model
`default_nettype wire

/* tb/status_conditional_jump_unit_test.sv */
// Self-checking bench for the status conditional jump unit
`timescale 1ns/10ps
`default_nettype none
module status_conditional_jump_unit_test;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic exec_valid_i = 1'b0;
    jump_unit_pkg::jump_kind_t exec_kind_i = jump_unit_pkg::jump_if_zero;
    logic [15:0] exec_pc_i = 16'h0000;
    logic [1:0] exec_length_i = 2'h1;
    logic [15:0] exec_disp_i = 16'h0000;
    logic arith_valid_i = 1'b0;
    logic [1:0] arith_cc_i = 2'h0;
    logic arith_overflow_i = 1'b0;
    logic [15:0] next_pc_o;
    logic [15:0] fetch_pc;
    logic done_o, redirect_o, flush_o, cc_high, cc_low, ovf, sticky;
    logic [1:0] cc_exp = 2'h0;
    logic ov_exp = 1'b0;
    logic os_exp = 1'b0;
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #10 clock_i = ~clock_i;

    status_conditional_jump_unit uut (.clock_i(clock_i), .reset_i(reset_i), .exec_valid_i(exec_valid_i),
        .exec_kind_i(exec_kind_i), .exec_pc_i(exec_pc_i), .exec_length_i(exec_length_i),
        .exec_disp_i(exec_disp_i), .arith_valid_i(arith_valid_i), .arith_cc_i(arith_cc_i),
        .arith_overflow_i(arith_overflow_i), .next_pc_o(next_pc_o), .done_o(done_o), .redirect_o(redirect_o),
        .flush_o(flush_o), .condition_code_high_o(cc_high), .condition_code_low_o(cc_low),
        .overflow_flag_o(ovf), .sticky_overflow_flag_o(sticky));
    code_memory_model mem (.clock_i(clock_i), .reset_i(reset_i), .done_i(done_o), .flush_i(flush_o),
        .next_pc_i(next_pc_o), .fetch_pc_o(fetch_pc));

    // ----------------------------------------
    // Compare and access tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic status_chk();
        chk({14'h0000, cc_high, cc_low}, {14'h0000, cc_exp}, "cc pair");
        chk({15'h0000, ovf}, {15'h0000, ov_exp}, "overflow");
        chk({15'h0000, sticky}, {15'h0000, os_exp}, "sticky");
    endtask : status_chk

    task automatic arith(input logic [1:0] cc, input logic ov);
        @(posedge clock_i);
        arith_valid_i <= 1'b1;
        arith_cc_i <= cc;
        arith_overflow_i <= ov;
        @(posedge clock_i);
        arith_valid_i <= 1'b0;
        cc_exp = cc;
        ov_exp = ov;
        os_exp = os_exp | ov;
        #1;
        status_chk();
    endtask : arith

    task automatic jump(input jump_unit_pkg::jump_kind_t k, input logic [15:0] pc, input logic [1:0] len,
                        input logic [15:0] disp, input logic mix = 1'b0, input logic [1:0] mix_cc = 2'h0,
                        input logic mix_ov = 1'b0);
        logic tk;
        logic [15:0] tgt;
        // Arithmetic finishing with the jump counts as done first
        if (mix) begin
            cc_exp = mix_cc;
            ov_exp = mix_ov;
            os_exp = os_exp | mix_ov;
        end
        case (k)
            jump_unit_pkg::jump_if_sticky_overflow: tk = os_exp;
            jump_unit_pkg::jump_if_overflow: tk = ov_exp;
            jump_unit_pkg::jump_if_zero: tk = (cc_exp == 2'h0);
            jump_unit_pkg::jump_if_nonzero: tk = (cc_exp == 2'h1) || (cc_exp == 2'h2);
            jump_unit_pkg::jump_if_positive: tk = (cc_exp == 2'h2);
            jump_unit_pkg::jump_if_negative: tk = (cc_exp == 2'h1);
            default: tk = (cc_exp == 2'h0) || (cc_exp == 2'h2);
        endcase
        tgt = tk ? pc + disp : pc + {14'h0000, len};
        @(posedge clock_i);
        exec_valid_i <= 1'b1;
        exec_kind_i <= k;
        exec_pc_i <= pc;
        exec_length_i <= len;
        exec_disp_i <= disp;
        arith_valid_i <= mix;
        arith_cc_i <= mix_cc;
        arith_overflow_i <= mix_ov;
        @(posedge clock_i);
        exec_valid_i <= 1'b0;
        arith_valid_i <= 1'b0;
        if (k == jump_unit_pkg::jump_if_sticky_overflow) os_exp = 1'b0;
        #1;
        chk({15'h0000, done_o}, 16'h0001, "done");
        chk({14'h0000, redirect_o, flush_o}, {14'h0000, tk, tk}, "redirect");
        chk(next_pc_o, tgt, "next pc");
        status_chk();
        @(posedge clock_i);
        #1;
        chk(fetch_pc, tgt, "fetch pc");
        chk({14'h0000, done_o, flush_o}, 16'h0000, "pulse end");
    endtask : jump

    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    // ----------------------------------------
    // Hang guard
    // ----------------------------------------
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            $display("BAD %0t timeout", $time);
            summarize();
        end
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clock_i);
        reset_i <= 1'b0;
        #1;
        chk(next_pc_o, 16'h0000, "reset pc");
        chk({11'h000, done_o, redirect_o, flush_o, ovf, sticky}, 16'h0000, "reset flags");
        status_chk();
        // Every pair value against every sign jump; 11 raises overflow too
        for (int c = 0; c < 4; c++) begin
            arith(c[1:0], c == 3);
            for (int k = 2; k < 7; k++) begin
                // Targets stay inside one block; odd kinds jump back 16 words, even kinds forward 32
                jump(jump_unit_pkg::jump_kind_t'(k[2:0]), 16'h1000, 2'(k % 3 + 1), k[0] ? 16'hfff0 : 16'h0020);
            end
        end
        arith(2'h2, 1'b0);
        jump(jump_unit_pkg::jump_if_overflow, 16'h2000, 2'h1, 16'h0010);
        jump(jump_unit_pkg::jump_if_sticky_overflow, 16'h2000, 2'h3, 16'hff00);
        jump(jump_unit_pkg::jump_if_sticky_overflow, 16'h2000, 2'h2, 16'hff00);
        arith(2'h1, 1'b1);
        jump(jump_unit_pkg::jump_if_overflow, 16'h3000, 2'h1, 16'h0004);
        jump(jump_unit_pkg::jump_if_negative, 16'h8000, 2'h1, 16'h7fff);
        jump(jump_unit_pkg::jump_if_negative, 16'h8000, 2'h1, 16'h8000);
        // Sticky jump to clear the flag, then results landing in the same cycle as the jump
        jump(jump_unit_pkg::jump_if_sticky_overflow, 16'h4000, 2'h1, 16'h0100);
        jump(jump_unit_pkg::jump_if_sticky_overflow, 16'h4000, 2'h2, 16'h0100, 1'b1, 2'h2, 1'b1);
        jump(jump_unit_pkg::jump_if_zero, 16'h5000, 2'h3, 16'hfffc, 1'b1, 2'h0, 1'b0);
        jump(jump_unit_pkg::jump_if_overflow, 16'h5000, 2'h1, 16'h0008, 1'b1, 2'h1, 1'b1);
        // Reset in mid-run drops a set sticky flag
        @(posedge clock_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        reset_i <= 1'b0;
        cc_exp = 2'h0;
        ov_exp = 1'b0;
        os_exp = 1'b0;
        #1;
        chk(next_pc_o, 16'h0000, "reset pc");
        status_chk();
        jump(jump_unit_pkg::jump_if_zero, 16'h0040, 2'h2, 16'h0010);
        summarize();
    end
endmodule : status_conditional_jump_unit_test
`default_nettype wire
